// ---- core/sdlc_top.sv ----
/*
  serial dac load control: the digital front end of a 16 bit voltage
  output converter. a host shifts words in under a frame select, the
  words reach the input register and then the dac register under the
  load strobe; clear forces midscale, power down asks for low power.
  assumes: serial_clk_in is the host's clock and stops outside frames;
  the frame and data pins change around its rising edge as a serial
  master would drive them; an external pull-up holds serial out high.
*/

//////////////////////////////////////////////////////////////////////
module sdlc_top (
  // system clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  // serial link, clocked by the host
  input  wire logic        serial_clk_in,
  input  wire logic        serial_frame_n_in,
  input  wire logic        serial_in,
  // open drain serial output
  input  wire logic        serial_out_in,
  output logic             serial_out_out,
  output logic             serial_out_oe_out,
  // control pins
  input  wire logic        load_strobe_n_in,
  input  wire logic        output_clear_n_in,
  input  wire logic        power_down_n_in,
  // converter side
  output logic [15:0]      dac_code_out,
  output logic [15:0]      dac_reg_out,
  output logic [15:0]      input_reg_out,
  output logic             output_clamped_out,
  output logic             power_save_out
);

  ////////////////////////////////////////////////////////////////////
  // link domain state, clocked by serial_clk_in falling edges

  logic [15:0] shift_reg;   // input shift register
  logic [4:0]  bit_cnt_reg; // edges seen in this frame
  logic [4:0]  bit_cnt_next;
  logic        armed_reg;   // no edge yet since frame fell
  logic        drive_reg;   // pull serial out low
  logic        word_full;   // sixteen or more edges this frame

  ////////////////////////////////////////////////////////////////////
  // frame end state, clocked by the frame select rising edge

  logic [15:0] hold_word_reg; // word handed to the system side
  logic        hold_sync_reg; // load was low when the frame ended
  logic        done_tgl_reg;  // flips once per complete frame

  ////////////////////////////////////////////////////////////////////
  // system domain state

  logic [4:0]  sync_raw;      // pins and toggle before crossing
  logic [4:0]  sync_meta_reg; // first stage, read only by second
  logic [4:0]  sync_reg;      // second stage, safe to use
  logic        frame_s;
  logic        load_s;
  logic        clear_s;
  logic        pwr_s;
  logic        tgl_s;
  logic        load_prev_reg; // load strobe one cycle back
  logic        tgl_seen_reg;  // last toggle value handled
  logic        tgl_event;
  logic        load_fall;
  logic        pending_reg;   // word waiting for buffer room
  logic [16:0] pend_data_reg; // that word with its mode flag
  logic [15:0] input_reg;     // input register
  logic [15:0] dac_reg;       // dac register
  logic [15:0] dac_next;
  logic [15:0] code_reg;      // code presented to the converter
  logic        pwr_save_reg;
  logic        pop_take;
  logic        sync_update;
  logic        dac_update;
  logic [15:0] pop_word;

  sdlc_pkg::sdlc_out_state_t out_state_reg;
  sdlc_pkg::sdlc_out_state_t out_state_next;

  sdlc_stream_if #(.WIDTH(sdlc_pkg::SDLC_ENTRY_W)) word_bus ();

  ////////////////////////////////////////////////////////////////////
  // link side

  // armed is forced while the frame is high, so the first falling
  // edge of every frame restarts the count without a second clock
  always_ff @(negedge serial_clk_in or negedge arst_n_in
              or posedge serial_frame_n_in) begin
    if (!arst_n_in) begin
      armed_reg <= 1'b1;
    end else if (serial_frame_n_in) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // count saturates so longer chained frames still count as full
  always_comb begin
    if (armed_reg) begin
      bit_cnt_next = sdlc_pkg::SDLC_CNT_ONE;
    end else if (bit_cnt_reg == sdlc_pkg::SDLC_CNT_FULL) begin
      bit_cnt_next = bit_cnt_reg;
    end else begin
      bit_cnt_next = bit_cnt_reg + sdlc_pkg::SDLC_CNT_INC;
    end
  end

  // edge counter, only advances inside a frame
  always_ff @(negedge serial_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt_reg <= sdlc_pkg::SDLC_CNT_RST;
    end else if (!serial_frame_n_in) begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // shift msb first; frozen while the frame is high
  always_ff @(negedge serial_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_reg <= sdlc_pkg::SDLC_MIDSCALE;
    end else if (!serial_frame_n_in) begin
      shift_reg <= {shift_reg[14:0], serial_in};
    end
  end

  // serial out follows the bit now at the msb end; registered so the
  // pin changes only on the falling edge, giving the next device in a
  // chain a full clock of setup
  always_ff @(negedge serial_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_reg <= ~sdlc_pkg::SDLC_MIDSCALE[sdlc_pkg::SDLC_MSB];
    end else if (!serial_frame_n_in) begin
      drive_reg <= ~shift_reg[14];
    end
  end

  // open drain: the pad only ever pulls low, a one is released
  assign serial_out_out    = 1'b0;
  assign serial_out_oe_out = drive_reg;

  // a frame with no edge leaves armed set, so a stale count from an
  // earlier frame cannot pass as a fresh word
  assign word_full = !armed_reg &&
                     (bit_cnt_reg == sdlc_pkg::SDLC_CNT_FULL);

  ////////////////////////////////////////////////////////////////////
  // frame end: the serial clock has stopped, the shift register is
  // quiet, so the word is captured on the frame's own rising edge

  always_ff @(posedge serial_frame_n_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_word_reg <= sdlc_pkg::SDLC_MIDSCALE;
      hold_sync_reg <= 1'b0;
      done_tgl_reg  <= 1'b0;
    end else if (word_full) begin
      hold_word_reg <= shift_reg;
      hold_sync_reg <= !load_strobe_n_in;
      done_tgl_reg  <= ~done_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crossing into the system clock

  assign sync_raw[sdlc_pkg::SDLC_S_FRAME] = serial_frame_n_in;
  assign sync_raw[sdlc_pkg::SDLC_S_LOAD]  = load_strobe_n_in;
  assign sync_raw[sdlc_pkg::SDLC_S_CLEAR] = output_clear_n_in;
  assign sync_raw[sdlc_pkg::SDLC_S_PWR]   = power_down_n_in;
  assign sync_raw[sdlc_pkg::SDLC_S_TGL]   = done_tgl_reg;

  // two stage synchroniser on every slow signal
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_meta_reg <= sdlc_pkg::SDLC_SYNC_RST;
      sync_reg      <= sdlc_pkg::SDLC_SYNC_RST;
    end else begin
      sync_meta_reg <= sync_raw;
      sync_reg      <= sync_meta_reg;
    end
  end

  assign frame_s = sync_reg[sdlc_pkg::SDLC_S_FRAME];
  assign load_s  = sync_reg[sdlc_pkg::SDLC_S_LOAD];
  assign clear_s = sync_reg[sdlc_pkg::SDLC_S_CLEAR];
  assign pwr_s   = sync_reg[sdlc_pkg::SDLC_S_PWR];
  assign tgl_s   = sync_reg[sdlc_pkg::SDLC_S_TGL];

  // edge history of the synchronised strobe and toggle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_prev_reg <= 1'b1;
      tgl_seen_reg  <= 1'b0;
    end else begin
      load_prev_reg <= load_s;
      tgl_seen_reg  <= tgl_s;
    end
  end

  assign tgl_event = tgl_s ^ tgl_seen_reg;
  // a strobe falling while a frame is open only selects the mode
  assign load_fall = load_prev_reg & ~load_s & frame_s;

  ////////////////////////////////////////////////////////////////////
  // word handoff into the buffer

  // the held word is stable for a whole frame after the toggle, so it
  // is read here without its own synchroniser; a new word wins over a
  // push in the same cycle, but one arriving while the buffer is full
  // and a word is still waiting replaces that waiting word
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending_reg   <= 1'b0;
      pend_data_reg <= {1'b0, sdlc_pkg::SDLC_MIDSCALE};
    end else if (tgl_event) begin
      pending_reg   <= 1'b1;
      pend_data_reg <= {hold_sync_reg, hold_word_reg};
    end else if (word_bus.push_ready) begin
      pending_reg   <= 1'b0;
    end
  end

  assign word_bus.push_valid = pending_reg;
  assign word_bus.push_data  = pend_data_reg;
  // draining pauses in power down, so words queue up meanwhile
  assign word_bus.pop_ready  = pwr_s;

  sdlc_fifo #(
    .WIDTH (sdlc_pkg::SDLC_ENTRY_W),
    .DEPTH (sdlc_pkg::SDLC_FIFO_DEPTH)
  ) u_fifo (
    .clk_in    (sys_clk_in),
    .arst_n_in (arst_n_in),
    .bus       (word_bus)
  );

  assign pop_take    = word_bus.pop_valid & word_bus.pop_ready;
  assign pop_word    = word_bus.pop_data[15:0];
  assign sync_update = pop_take &
                       word_bus.pop_data[sdlc_pkg::SDLC_ENTRY_SYNC];
  assign dac_update  = sync_update | load_fall;

  ////////////////////////////////////////////////////////////////////
  // input and dac registers

  // input register takes every drained word
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      input_reg <= sdlc_pkg::SDLC_MIDSCALE;
    end else if (pop_take) begin
      input_reg <= pop_word;
    end
  end

  // a word framed with load low goes straight through; otherwise the
  // strobe edge copies the input register as it was before this cycle
  always_comb begin
    if (sync_update) begin
      dac_next = pop_word;
    end else if (load_fall) begin
      dac_next = input_reg;
    end else begin
      dac_next = dac_reg;
    end
  end

  // clear never touches this register
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dac_reg <= sdlc_pkg::SDLC_MIDSCALE;
    end else begin
      dac_reg <= dac_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output clamp sequencing

  always_comb begin
    out_state_next = out_state_reg;
    case (out_state_reg)
      sdlc_pkg::SDLC_OUT_TRACK: begin
        if (!clear_s) begin
          out_state_next = sdlc_pkg::SDLC_OUT_CLAMPED;
        end
      end
      sdlc_pkg::SDLC_OUT_CLAMPED: begin
        if (clear_s) begin
          out_state_next = sdlc_pkg::SDLC_OUT_HELD;
        end
      end
      sdlc_pkg::SDLC_OUT_HELD: begin
        if (!clear_s) begin
          out_state_next = sdlc_pkg::SDLC_OUT_CLAMPED;
        end else if (dac_update) begin
          out_state_next = sdlc_pkg::SDLC_OUT_TRACK;
        end
      end
      default: begin
        out_state_next = sdlc_pkg::SDLC_OUT_CLAMPED;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_state_reg <= sdlc_pkg::SDLC_OUT_TRACK;
    end else begin
      out_state_reg <= out_state_next;
    end
  end

  // converter code: midscale is the zero volt point of the straight
  // binary scale, so clamping is simply presenting that code
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_reg <= sdlc_pkg::SDLC_MIDSCALE;
    end else if (out_state_next == sdlc_pkg::SDLC_OUT_TRACK) begin
      code_reg <= dac_next;
    end else begin
      code_reg <= sdlc_pkg::SDLC_MIDSCALE;
    end
  end

  // low power request for the analog core
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwr_save_reg <= 1'b0;
    end else begin
      pwr_save_reg <= ~pwr_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign dac_code_out       = code_reg;
  assign dac_reg_out        = dac_reg;
  assign input_reg_out      = input_reg;
  assign output_clamped_out =
    (out_state_reg != sdlc_pkg::SDLC_OUT_TRACK);
  assign power_save_out     = pwr_save_reg;

endmodule // sdlc_top

// ---- pkg/sdlc_pkg.sv ----
/*
  shared constants and types of the serial dac load control block:
  word layout, preset codes, counter widths, buffer sizing, the order
  of the synchronised pin vector and the output state encoding.
  assumes nothing beyond a systemverilog compiler.
*/
package sdlc_pkg;

  ////////////////////////////////////////////////////////////////////
  // word and code layout
  localparam int          SDLC_WORD_W   = 16;      // serial word width
  localparam logic [15:0] SDLC_MIDSCALE = 16'h8000; // zero volt code
  localparam int          SDLC_MSB      = 15;      // first bit on wire

  ////////////////////////////////////////////////////////////////////
  // falling edge counter of one frame
  localparam int         SDLC_CNT_W   = 5;
  localparam logic [4:0] SDLC_CNT_RST = 5'h00;  // after reset
  localparam logic [4:0] SDLC_CNT_ONE = 5'h01;  // first edge of frame
  localparam logic [4:0] SDLC_CNT_INC = 5'h01;  // step per edge
  localparam logic [4:0] SDLC_CNT_FULL = 5'h10; // edges per word

  ////////////////////////////////////////////////////////////////////
  // word buffer: update mode flag above the 16 data bits
  localparam int SDLC_ENTRY_W    = 17;
  localparam int SDLC_ENTRY_SYNC = 16; // bit set: load low in frame
  localparam int SDLC_FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////
  // synchronised pin vector, bit positions and reset values
  localparam int         SDLC_SYNC_N  = 5;
  localparam int         SDLC_S_FRAME = 0;
  localparam int         SDLC_S_LOAD  = 1;
  localparam int         SDLC_S_CLEAR = 2;
  localparam int         SDLC_S_PWR   = 3;
  localparam int         SDLC_S_TGL   = 4;
  localparam logic [4:0] SDLC_SYNC_RST = 5'h0F; // pins idle high

  ////////////////////////////////////////////////////////////////////
  // clock rates
  localparam int SDLC_SYS_CLK_HZ   = 20000000;
  localparam int SDLC_LINK_MAX_HZ  = 8000000; // host side ceiling

  ////////////////////////////////////////////////////////////////////
  // output state
  typedef enum logic [1:0] {
    SDLC_OUT_TRACK   = 2'b00, // converter follows dac register
    SDLC_OUT_CLAMPED = 2'b01, // clear held low
    SDLC_OUT_HELD    = 2'b10  // clear released, waiting for load
  } sdlc_out_state_t;

endpackage : sdlc_pkg

// ---- pkg/sdlc_stream_if.sv ----
/*
  valid/ready stream between the control core and its word buffer.
  assumes both ends run on the same system clock.
*/
interface sdlc_stream_if #(
  parameter int WIDTH = 17
);

  logic             push_valid; // word offered to buffer
  logic             push_ready; // buffer has room
  logic [WIDTH-1:0] push_data;  // offered word
  logic             pop_valid;  // buffer holds a word
  logic             pop_ready;  // consumer takes it
  logic [WIDTH-1:0] pop_data;   // oldest word

  // the buffer itself
  modport buffer (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );

  // the core that fills and drains it
  modport client (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data
  );

endinterface : sdlc_stream_if

// ---- core/sdlc_fifo.sv ----
/*
  small first-in first-out word buffer in flip-flops.
  assumes one clock and an active low asynchronous reset.
*/
module sdlc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic     clk_in,
  input  wire logic     arst_n_in,
  // both stream sides
  sdlc_stream_if.buffer bus
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [IDX_W-1:0] LAST  = IDX_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULLC = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage
  logic [IDX_W-1:0] wr_reg;          // next slot to write
  logic [IDX_W-1:0] rd_reg;          // oldest slot
  logic [CNT_W-1:0] cnt_reg;         // words held
  logic             do_push;
  logic             do_pop;

  // full and empty come straight from the count
  assign bus.push_ready = (cnt_reg != FULLC);
  assign bus.pop_valid  = (cnt_reg != '0);
  assign bus.pop_data   = mem_reg[rd_reg];
  assign do_push = bus.push_valid & bus.push_ready;
  assign do_pop  = bus.pop_valid & bus.pop_ready;

  ////////////////////////////////////////////////////////////////////
  // storage write, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_reg[wr_reg] <= bus.push_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + IDX_W'(1);
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + IDX_W'(1);
      end
    end
  end

  // occupancy
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
    end else if (do_push && !do_pop) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end else if (do_pop && !do_push) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

endmodule // sdlc_fifo

// ---- verif/sdlc_checker.sv ----
/*
  concurrent checks on the ports of the serial dac load control top.
  assumes the link clock stops outside frames and idles high.
*/
module sdlc_checker (
  // system side
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  // serial link
  input wire logic        serial_clk_in,
  input wire logic        serial_frame_n_in,
  input wire logic        serial_in,
  input wire logic        serial_out_in,
  input wire logic        serial_out_out,
  input wire logic        serial_out_oe_out,
  // control pins
  input wire logic        load_strobe_n_in,
  input wire logic        output_clear_n_in,
  input wire logic        power_down_n_in,
  // converter side
  input wire logic [15:0] dac_code_out,
  input wire logic [15:0] dac_reg_out,
  input wire logic [15:0] input_reg_out,
  input wire logic        output_clamped_out,
  input wire logic        power_save_out
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////
  // in-frame falls since the last idle fall; the clock stops between
  // frames, so the count spans frames and $past stays aligned
  logic [4:0] run_reg;
  always_ff @(negedge serial_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) run_reg <= 5'h00;
    else if (serial_frame_n_in) run_reg <= 5'h00;
    else if (run_reg != 5'h1F) run_reg <= run_reg + 5'h01;
  end

  // load falling while idle, pins otherwise quiet
  sequence s_load_fall;
    $fell(load_strobe_n_in) && serial_frame_n_in && output_clear_n_in;
  endsequence

  ////////////////////////////////////////////////////////////////////
  a_oe_daisy_msb: assert property (
    @(negedge serial_clk_in) disable iff (!arst_n_in)
    !serial_frame_n_in && run_reg >= 5'h0F
    |=> serial_out_oe_out == !$past(serial_in, 16))
    else $error("serial out does not forward the old bit");
  a_idle_oe_hold: assert property (
    @(negedge serial_clk_in) disable iff (!arst_n_in)
    serial_frame_n_in |=> $stable(serial_out_oe_out))
    else $error("serial out moved outside a frame");
  a_out_pin_low: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    serial_out_out == 1'b0)
    else $error("open drain data value is not low");
  a_clamp_mid: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    output_clamped_out |-> dac_code_out == 16'h8000)
    else $error("clamped output is not midscale");
  a_track_code: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    !output_clamped_out |-> dac_code_out == dac_reg_out)
    else $error("converter code differs from dac register");
  a_clear_keeps_regs: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(output_clamped_out)
    |-> $stable(dac_reg_out) && $stable(input_reg_out))
    else $error("clear touched a register");
  a_clear_clamps: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $fell(output_clear_n_in) |-> ##[1:4] output_clamped_out)
    else $error("clear did not clamp the output");
  a_pwr_follows: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $changed(power_down_n_in)
    |-> ##[1:4] power_save_out == !power_down_n_in)
    else $error("power save does not follow its pin");
  a_load_updates: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    s_load_fall |-> ##[2:4] dac_reg_out == input_reg_out
    && dac_code_out == input_reg_out)
    else $error("load strobe did not update the output");
  a_reset_mid: assert property (
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    $rose(arst_n_in) |-> dac_reg_out == 16'h8000
    && input_reg_out == 16'h8000 && !serial_out_oe_out)
    else $error("registers not at midscale after reset");

endmodule // sdlc_checker

bind sdlc_top sdlc_checker chk (.sys_clk_in, .arst_n_in, .serial_clk_in,
  .serial_frame_n_in, .serial_in, .serial_out_in, .serial_out_out,
  .serial_out_oe_out, .load_strobe_n_in, .output_clear_n_in,
  .power_down_n_in, .dac_code_out, .dac_reg_out, .input_reg_out,
  .output_clamped_out, .power_save_out);

// ---- verif/sdlc_host_model.sv ----
/*
  serial master in the host's place: frames words msb first and
  records the pin read back before each falling edge.
  assumes an external pull-up on the serial output pin.
*/
module sdlc_host_model (
  // link toward the device
  output logic        serial_clk_out,
  output logic        frame_n_out,
  output logic        data_out,
  // open drain pin from the device
  input  wire logic   line_val_in,
  input  wire logic   line_oe_in,
  output logic        line_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam time HALF = 64ns; // 7.8 MHz, under the link ceiling
  logic [31:0] rx_reg;         // readback, oldest bit highest

  initial begin
    serial_clk_out = 1'b1; // idles high, stands still between frames except in idle_toggle
    frame_n_out    = 1'b1;
    data_out       = 1'b0;
    rx_reg         = 32'h0000_0000;
  end

  // released pin is pulled high
  assign line_pin_out = line_oe_in ? line_val_in : 1'b1;

  // one frame of n bits, msb first
  task automatic send(input logic [31:0] w, input int n);
    #13ns frame_n_out = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      data_out = w[i];
      rx_reg = {rx_reg[30:0], line_pin_out};
      #(HALF) serial_clk_out = 1'b0;
      #(HALF) serial_clk_out = 1'b1;
    end
    #(HALF) frame_n_out = 1'b1;
    data_out = ~data_out; // no stale bit once the frame is over
    #(HALF);
  endtask

  // clock and data toggling with the frame idle
  task automatic idle_toggle(input int n);
    repeat (n) begin
      data_out = ~data_out;
      #(HALF) serial_clk_out = 1'b0;
      #(HALF) serial_clk_out = 1'b1;
    end
  endtask

endmodule // sdlc_host_model

// ---- verif/sdlc_top_test.sv ----
/*
  self-checking bench of the serial dac load control top.
  assumes the host model and the checker bound to the top.
*/
module sdlc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic        load_n     = 1'b1; // load strobe pin
  logic        clear_n    = 1'b1; // output clear pin
  logic        power_down_n = 1'b1; // power down pin
  wire         sclk, frame_n, sdi, so_pin, so_val, so_oe;
  wire         clamped, psave;
  wire  [15:0] dac_code, dac_reg, input_reg;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;

  always #25 sys_clk_in = ~sys_clk_in; // 20 MHz

  sdlc_top uut (.sys_clk_in, .arst_n_in, .serial_clk_in(sclk),
    .serial_frame_n_in(frame_n), .serial_in(sdi), .serial_out_in(so_pin),
    .serial_out_out(so_val), .serial_out_oe_out(so_oe),
    .load_strobe_n_in(load_n), .output_clear_n_in(clear_n),
    .power_down_n_in(power_down_n), .dac_code_out(dac_code),
    .dac_reg_out(dac_reg),
    .input_reg_out(input_reg), .output_clamped_out(clamped),
    .power_save_out(psave));
  sdlc_host_model host (.serial_clk_out(sclk), .frame_n_out(frame_n),
    .data_out(sdi), .line_val_in(so_val), .line_oe_in(so_oe),
    .line_pin_out(so_pin));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // settle to a falling system edge, where pins are driven
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_async_load;
    host.send(32'h0000_A5C3, 16);
    wt(10);
    chk(input_reg, 16'hA5C3);
    chk(dac_code, 16'h8000);
    chk(host.rx_reg[15:0], 16'h8000);
    load_n = 1'b0;
    wt(5);
    chk(dac_code, 16'hA5C3);
    load_n = 1'b1;
    wt(3);
  endtask
  // idle toggling, then a short frame: neither reaches the registers
  task automatic t_idle_short;
    host.idle_toggle(20);
    host.send(32'h0000_0ABC, 12);
    wt(10);
    chk(input_reg, 16'hA5C3);
    chk(dac_code, 16'hA5C3);
  endtask
  // load tied low, a frame rise updates; readback shows old contents
  task automatic t_sync_daisy;
    load_n = 1'b0;
    wt(5);
    host.send(32'h0000_FFFF, 16);
    wt(10);
    chk(dac_code, 16'hFFFF);
    chk(host.rx_reg[15:0], 16'h3ABC);
    host.send(32'h1357_2468, 32);
    wt(10);
    chk(dac_reg, 16'h2468);
    chk(host.rx_reg[31:16], 16'hFFFF);
    chk(host.rx_reg[15:0], 16'h1357);
    load_n = 1'b1;
    wt(3);
  endtask
  task automatic t_clear;
    clear_n = 1'b0;
    wt(6);
    chk(dac_code, 16'h8000);
    chk(dac_reg, 16'h2468);
    clear_n = 1'b1;
    wt(6);
    chk(dac_code, 16'h8000);
    load_n = 1'b0;
    wt(5);
    chk(dac_code, 16'h2468);
    load_n = 1'b1;
    wt(3);
  endtask
  // words queue while powered down until the buffer refuses
  task automatic t_power;
    power_down_n = 1'b0;
    wt(6);
    chk({15'h0000, psave}, 16'h0001);
    for (int i = 0; i < 6; i++) host.send(32'h0000_1000 + i, 16);
    wt(10);
    chk(input_reg, 16'h2468);
    power_down_n = 1'b1;
    wt(20);
    chk(input_reg, 16'h1005);
    chk(dac_code, 16'h2468);
    chk({15'h0000, psave}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    wt(4);
    chk(input_reg, 16'h8000);
    chk(dac_code, 16'h8000);
    t_async_load;
    t_idle_short;
    t_sync_daisy;
    t_clear;
    t_power;
    finish_test;
  end

  // hang guard, far above the some 660 cycles the run needs
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end

endmodule // sdlc_top_test
